// ==== hdl/urm_top.sv ====
`default_nettype none
module urm_top
  import urm_pkg::*;
(
  input  wire logic                      mclk,
  input  wire logic                      arst_n,
  input  wire logic                      sclk,
  input  wire logic                      cs_n,
  input  wire logic                      din,
  output logic                           dout,
  output logic                           dout_oe,
  input  wire urm_ro_s                   ro,
  output logic [URM_NRW-1:0][15:0]       cfg_words,
  output urm_cmd_s                       cmd
);

  logic [2:0]               sclk_sync;
  logic [2:0]               cs_sync;
  logic [1:0]               din_sync;
  logic                     sclk_rise;
  logic                     sclk_fall;
  logic                     cs_s;
  logic                     din_s;
  logic [URM_CNT_W-1:0]     bit_cnt;
  logic [14:0]              rx_sr;
  logic [15:0]              tx_sr;
  logic                     frame_done;
  logic [15:0]              frame;
  logic                     fr_write;
  logic [6:0]               fr_addr;
  logic [7:0]               fr_data;
  logic [15:0]              rd_word;

  // Pins come from the master's domain; two stages before any use
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_sync <= 3'h7;
      cs_sync   <= 3'h7;
      din_sync  <= 2'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], sclk};
      cs_sync   <= {cs_sync[1:0], cs_n};
      din_sync  <= {din_sync[0], din};
    end
  end

  // Edges taken from the second and third stages only
  assign sclk_rise  = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall  = ~sclk_sync[1] & sclk_sync[2];
  assign cs_s       = cs_sync[1];
  assign din_s      = din_sync[1];
  assign frame_done = ~cs_s & sclk_rise & (bit_cnt == URM_CNT_W'(URM_FRAME_BITS - 1));
  assign frame      = {rx_sr, din_s};
  assign fr_write   = frame[15];
  assign fr_addr    = frame[14:8];
  assign fr_data    = frame[7:0];

  // Rising-edge capture, MSB first; a high chip select abandons the frame
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= '0;
      rx_sr   <= '0;
    end else if (cs_s) begin
      bit_cnt <= '0;
    end else if (sclk_rise) begin
      rx_sr   <= {rx_sr[13:0], din_s};
      bit_cnt <= frame_done ? '0 : bit_cnt + URM_CNT_W'(1);
    end
  end

  // Word read mux; the pair is addressed by its even byte
  always_comb begin
    rd_word = URM_WORD_RST;
    case ({fr_addr[6:1], 1'b0})
      URM_FLASH_WRITE_COUNTER: rd_word = ro.flash_write_counter;
      URM_SUPPLY:    rd_word = ro.supply_voltage_out;
      URM_ACC_X:     rd_word = ro.accel_x_out;
      URM_ACC_Y:     rd_word = ro.accel_y_out;
      URM_ACC_Z:     rd_word = ro.accel_z_out;
      URM_TEMP:      rd_word = ro.temperature_out;
      URM_INC_X:     rd_word = ro.incline_x_out;
      URM_INC_Y:     rd_word = ro.incline_y_out;
      URM_INC_Z:     rd_word = ro.incline_z_out;
      URM_ALIGN_X:   rd_word = ro.x_alignment_reference;
      URM_ALIGN_Y:   rd_word = ro.y_alignment_reference;
      URM_ALIGN_Z:   rd_word = ro.z_alignment_reference;
      URM_STATUS:    rd_word = ro.system_status;
      URM_COMMAND:   rd_word = URM_WORD_RST;
      URM_LOT_ONE:   rd_word = ro.lot_code_one;
      URM_LOT_TWO:   rd_word = ro.lot_code_two;
      URM_PRODUCT:   rd_word = ro.product_code;
      URM_SERIAL:    rd_word = ro.unit_serial_number;
      default: begin
        for (int i = 0; i < URM_NRW; i++) begin
          if ({fr_addr[6:1], 1'b0} == URM_RW_OFS[i]) begin
            rd_word = cfg_words[i];
          end
        end
      end
    endcase
  end

  // Reply register: loaded at frame end, shifted on falling edges.
  // The first falling edge of a frame only exposes the MSB, so no shift.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sr <= URM_WORD_RST;
    end else if (frame_done) begin
      tx_sr <= fr_write ? URM_WORD_RST : rd_word;
    end else if (~cs_s & sclk_fall & (bit_cnt != '0)) begin
      tx_sr <= {tx_sr[14:0], 1'b0};
    end
  end

  // Driver enable follows chip select so the line can be shared
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dout_oe <= 1'b0;
    end else begin
      dout_oe <= ~cs_s;
    end
  end

  assign dout = tx_sr[15];

  // Byte writes into the read/write bank; other addresses fall through.
  // Flash retention of this bank belongs to the flash logic outside.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_words <= '0;
    end else if (frame_done & fr_write) begin
      for (int i = 0; i < URM_NRW; i++) begin
        if ({fr_addr[6:1], 1'b0} == URM_RW_OFS[i]) begin
          if (fr_addr[0]) begin
            cfg_words[i][15:8] <= fr_data;
          end else begin
            cfg_words[i][7:0] <= fr_data;
          end
        end
      end
    end
  end

  // Command byte is a one-cycle strobe; nothing is kept for reading
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
    end else begin
      cmd.valid <= frame_done & fr_write & ({fr_addr[6:1], 1'b0} == URM_COMMAND);
      if (frame_done & fr_write) begin
        cmd.high <= fr_addr[0];
        cmd.data <= fr_data;
      end
    end
  end

  // Checks next to the logic they guard
  tri_state_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cs_s |=> !dout_oe) else $error("output driven while deselected");

  cmd_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd.valid |=> !cmd.valid) else $error("command strobe longer than one cycle");

  read_reply_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && !fr_write |=> tx_sr == $past(rd_word))
    else $error("reply word not loaded after read");

  write_quiet_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write |=> tx_sr == URM_WORD_RST)
    else $error("data shifted after a write frame");

  flash_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && !fr_write && fr_addr == URM_FLASH_WRITE_COUNTER
      |=> tx_sr == $past(ro.flash_write_counter))
    else $error("flash counter not returned");

  ro_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr <= URM_INC_Z + 7'h01 |=> $stable(cfg_words))
    else $error("write to read-only output changed bank");

  avg_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == URM_DEC_FILT
      |=> cfg_words[URM_DEC_SLOT][7:0] == $past(fr_data)
          && $stable(cfg_words[URM_DEC_SLOT][15:8]))
    else $error("filter low byte write wrong");

  high_byte_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == URM_DEC_FILT + 7'h01
      |=> cfg_words[URM_DEC_SLOT][15:8] == $past(fr_data)
          && $stable(cfg_words[URM_DEC_SLOT][7:0]))
    else $error("filter high byte write wrong");

  bit_count_a: assert property (@(posedge mclk) disable iff (!arst_n)
    bit_cnt < URM_CNT_W'(URM_FRAME_BITS)) else $error("frame bit count overran");

  // A deselect always restarts the bit count, so a cut frame never writes
  cut_frame_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cs_s |=> bit_cnt == '0) else $error("bit count kept across deselect");

  // Driver is on whenever the synced select is low
  drive_on_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !cs_s |=> dout_oe) else $error("output not driven while selected");

  // Alignment references stay out of reach of host writes
  align_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && {fr_addr[6:1], 1'b0} == URM_ALIGN_X |=> $stable(cfg_words))
    else $error("write to alignment reference changed bank");

  // Status and the identity words are never written
  status_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && {fr_addr[6:1], 1'b0} == URM_STATUS |=> $stable(cfg_words))
    else $error("write to status changed bank");

  ident_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr >= URM_LOT_ONE && fr_addr <= URM_SERIAL + 7'h01
      |=> $stable(cfg_words))
    else $error("write to identity word changed bank");

  // Reserved word at 0x1E has no storage behind it
  reserved_ignore_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && {fr_addr[6:1], 1'b0} == 7'h1e |=> $stable(cfg_words))
    else $error("write to reserved word changed bank");

  // One slot from each writable group takes a byte: its low byte, or its high byte for the bias slot
  null_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == URM_RW_OFS[0]
      |=> cfg_words[0][7:0] == $past(fr_data))
    else $error("offset null low byte write wrong");

  alarm_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == URM_RW_OFS[3]
      |=> cfg_words[3][7:0] == $past(fr_data))
    else $error("alarm threshold low byte write wrong");

  gpio_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == URM_RW_OFS[11]
      |=> cfg_words[11][7:0] == $past(fr_data))
    else $error("general io low byte write wrong");

  bias_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    frame_done && fr_write && fr_addr == (URM_RW_OFS[18] | 7'h01)
      |=> cfg_words[18][15:8] == $past(fr_data))
    else $error("bias high byte write wrong");

  // Command byte data follows the frame that carried it
  cmd_data_a: assert property (@(posedge mclk) disable iff (!arst_n)
    cmd.valid |-> $past(fr_data) == cmd.data) else $error("command byte lost");

endmodule : urm_top
`default_nettype wire

// ==== hdl/urm_pkg.sv ====
// Overview of operation
// - Each write frame changes at most one byte at one byte address; writes to read-only words change none.
// - Register low byte sits at even address, high byte at next odd address.
// - Writing 0x07 to 0x38 stores averaging 128, output rate 4 SPS.
// - Register data shifts out only in the frame after a read request.
// - Serial output is released while chip select is high.
// - Flash write counter at 0x00 is read-only 16-bit count.
// - Output registers 0x02 to 0x10 are read-only, not flash backed.
// - Offset null registers 0x12, 0x14, 0x16 are read/write, flash backed.
// - Alignment references 0x18, 0x1A, 0x1C are read-only, flash backed.
// - Alarm registers 0x20 to 0x2E are read/write, flash backed.
// - Configuration registers 0x32 to 0x3A are read/write, flash backed.
// - Status register 0x3C is read-only, not flash backed.
// - Command register 0x3E is write-only, reads nothing, not flash backed.
// - Lot, product and serial registers 0x52 to 0x58 are read-only.
// - Internal bias registers 0x70, 0x72, 0x74 are read/write, flash backed.
// - Clock idles high, capture on rising edge, 16-bit frames, MSB first.
// - Read takes two frames; second frame may carry next request.
`default_nettype none
package urm_pkg;
  localparam int URM_FRAME_BITS = 16;
  localparam int URM_NRW        = 19;
  localparam int URM_CNT_W      = 5;
  localparam logic [6:0] URM_FLASH_WRITE_COUNTER = 7'h00;
  localparam logic [6:0] URM_SUPPLY    = 7'h02;
  localparam logic [6:0] URM_ACC_X     = 7'h04;
  localparam logic [6:0] URM_ACC_Y     = 7'h06;
  localparam logic [6:0] URM_ACC_Z     = 7'h08;
  localparam logic [6:0] URM_TEMP      = 7'h0a;
  localparam logic [6:0] URM_INC_X     = 7'h0c;
  localparam logic [6:0] URM_INC_Y     = 7'h0e;
  localparam logic [6:0] URM_INC_Z     = 7'h10;
  localparam logic [6:0] URM_ALIGN_X   = 7'h18;
  localparam logic [6:0] URM_ALIGN_Y   = 7'h1a;
  localparam logic [6:0] URM_ALIGN_Z   = 7'h1c;
  localparam logic [6:0] URM_STATUS    = 7'h3c;
  localparam logic [6:0] URM_COMMAND   = 7'h3e;
  localparam logic [6:0] URM_LOT_ONE   = 7'h52;
  localparam logic [6:0] URM_LOT_TWO   = 7'h54;
  localparam logic [6:0] URM_PRODUCT   = 7'h56;
  localparam logic [6:0] URM_SERIAL    = 7'h58;
  localparam logic [6:0] URM_DEC_FILT  = 7'h38;
  // Read/write, flash backed registers; slot n of the config output
  localparam logic [6:0] URM_RW_OFS [URM_NRW] = '{
    7'h12, 7'h14, 7'h16, 7'h20, 7'h22, 7'h24, 7'h26, 7'h28, 7'h2a, 7'h2c,
    7'h2e, 7'h32, 7'h34, 7'h36, URM_DEC_FILT, 7'h3a, 7'h70, 7'h72, 7'h74};
  localparam int URM_DEC_SLOT = 14;
  localparam logic [15:0] URM_WORD_RST = 16'h0000;

  // Values produced by the sensor and flash logic of the device
  typedef struct packed {
    logic [15:0] flash_write_counter;
    logic [15:0] supply_voltage_out;
    logic [15:0] accel_x_out;
    logic [15:0] accel_y_out;
    logic [15:0] accel_z_out;
    logic [15:0] temperature_out;
    logic [15:0] incline_x_out;
    logic [15:0] incline_y_out;
    logic [15:0] incline_z_out;
    logic [15:0] x_alignment_reference;
    logic [15:0] y_alignment_reference;
    logic [15:0] z_alignment_reference;
    logic [15:0] system_status;
    logic [15:0] lot_code_one;
    logic [15:0] lot_code_two;
    logic [15:0] product_code;
    logic [15:0] unit_serial_number;
  } urm_ro_s;

  // Byte written to the command register
  typedef struct packed {
    logic       valid;
    logic       high;
    logic [7:0] data;
  } urm_cmd_s;
endpackage : urm_pkg
`default_nettype wire

// ==== verification/urm_spi_host.sv ====
`default_nettype none
// Host side of the serial link: clock idles high, 16-bit frames, MSB first
module urm_spi_host (
  input  wire logic        mclk,
  input  wire logic        dout,
  input  wire logic        dout_oe,
  output logic             sclk,
  output logic             cs_n,
  output logic             din,
  output logic [15:0]      rx,
  output logic             done
);
  timeunit 1ns;
  timeprecision 1ps;
  // 61 clocks per half period gives 820 kHz; slow, but within the host limit
  localparam int HALF = 61;
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din  = 1'b0;
    rx   = 16'h0000;
    done = 1'b0;
  end
  // Sends nb bits; fewer than 16 cuts the frame by raising chip select
  task automatic xfer(input logic [15:0] tx, input int nb);
    cs_n <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int i = 15; i > 15 - nb; i--) begin
      sclk <= 1'b0;
      din  <= tx[i];
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      // A released line reads as z, so a missing drive cannot pass
      rx = {rx[14:0], dout_oe ? dout : 1'bz};
      repeat (HALF) @(posedge mclk);
    end
    cs_n <= 1'b1;
    din  <= ~din; // Idle line shows no stale bit
    done <= (nb == 16);
    @(posedge mclk);
    done <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask
endmodule // urm_spi_host
`default_nettype wire

// ==== verification/urm_top_tb.sv ====
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module urm_top_tb import urm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     mclk = 1'b0;
  logic                     arst_n = 1'b0;
  logic                     sclk, cs_n, din, dout, dout_oe, done;
  logic [15:0]              rx;
  urm_ro_s                  ro;
  logic [URM_NRW-1:0][15:0] cfg_words;
  urm_cmd_s                 cmd;
  logic [15:0]              shadow [URM_NRW];
  logic [16:0]              exp_q [$];
  logic [16:0]              nxt = 17'h0_0000;
  logic [16:0]              e_now;
  int                       fails = 0;
  int                       checked = 0;
  int                       cyc = 0;
  int                       ncmd = 0;
  int                       seed = 32'h91e2_5104;
  localparam logic [6:0] RO_OFS [17] = '{URM_FLASH_WRITE_COUNTER, URM_SUPPLY, URM_ACC_X, URM_ACC_Y,
    URM_ACC_Z, URM_TEMP, URM_INC_X, URM_INC_Y, URM_INC_Z, URM_ALIGN_X, URM_ALIGN_Y,
    URM_ALIGN_Z, URM_STATUS, URM_LOT_ONE, URM_LOT_TWO, URM_PRODUCT, URM_SERIAL};
  always #5 mclk = ~mclk;
  urm_top u_urm_top (.mclk(mclk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .dout_oe(dout_oe), .ro(ro), .cfg_words(cfg_words), .cmd(cmd));
  urm_spi_host u_urm_spi_host (.mclk(mclk), .dout(dout), .dout_oe(dout_oe), .sclk(sclk),
    .cs_n(cs_n), .din(din), .rx(rx), .done(done));
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Expected reply word: whole word of the even address, zero where nothing reads
  function automatic logic [15:0] rd_exp(input logic [6:0] a);
    logic [6:0] e;
    e = {a[6:1], 1'b0};
    rd_exp = 16'h0000;
    for (int s = 0; s < URM_NRW; s++) if (URM_RW_OFS[s] == e) rd_exp = shadow[s];
    for (int k = 0; k < 17; k++) if (RO_OFS[k] == e) rd_exp = ro[271-16*k -: 16];
  endfunction
  // One full frame; notes the reply it should carry, then checks the bank
  task automatic op(input logic w, input logic [6:0] a, input logic [7:0] d);
    exp_q.push_back(nxt);
    nxt = w ? 17'h1_0000 : {1'b1, rd_exp(a)};
    u_urm_spi_host.xfer({w, a, d}, 16);
    for (int s = 0; s < URM_NRW; s++) begin
      if (w && URM_RW_OFS[s] == {a[6:1], 1'b0}) begin
        if (a[0]) shadow[s][15:8] = d;
        else shadow[s][7:0] = d;
      end
      `CHK(cfg_words[s], shadow[s])
    end
    `CHK(dout_oe, 1'b0)
  endtask
  // Reply watcher, command strobe counter and hang limit
  always @(posedge mclk) begin
    if (done && exp_q.size() > 0) begin
      e_now = exp_q.pop_front();
      if (e_now[16]) `CHK(rx, e_now[15:0])
    end
    if (cmd.valid === 1'b1) ncmd++;
    cyc++;
    if (cyc == 120000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    for (int s = 0; s < URM_NRW; s++) shadow[s] = 16'h0000;
    for (int k = 0; k < 17; k++) ro[271-16*k -: 16] = 16'($random(seed));
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(dout_oe, 1'b0)
    // Writes to read-only words must be dropped
    op(1'b1, URM_FLASH_WRITE_COUNTER, 8'hff);
    op(1'b1, URM_ALIGN_X | 7'h01, 8'h5a);
    op(1'b1, URM_STATUS, 8'ha5);
    for (int k = 0; k < 17; k++) op(1'b0, RO_OFS[k] | 7'(k & 1), 8'h00);
    // Reserved and write-only words read as zero; the host never writes 0x1E
    op(1'b0, 7'h1f, 8'h00);
    op(1'b0, 7'h30, 8'h00);
    op(1'b0, 7'h4b, 8'h00);
    op(1'b0, URM_COMMAND, 8'h00);
    for (int s = 0; s < URM_NRW; s++) op(1'b1, URM_RW_OFS[s] | 7'(s & 1), 8'($random(seed)));
    op(1'b1, URM_DEC_FILT, 8'h07);
    `CHK(cfg_words[URM_DEC_SLOT][7:0], 8'h07)
    op(1'b1, URM_COMMAND, 8'h5a);
    `CHK({cmd.high, cmd.data}, 9'h05a)
    op(1'b1, URM_COMMAND | 7'h01, 8'ha5);
    `CHK({cmd.high, cmd.data}, 9'h1a5)
    `CHK(ncmd, 2)
    // A write cut off mid-frame leaves no trace
    u_urm_spi_host.xfer(16'h92ff, 12);
    nxt = 17'h0_0000;
    op(1'b0, URM_RW_OFS[0], 8'h00);
    op(1'b0, URM_DEC_FILT | 7'h01, 8'h00);
    op(1'b0, URM_RW_OFS[10], 8'h00);
    op(1'b0, URM_RW_OFS[18] | 7'h01, 8'h00);
    op(1'b0, URM_FLASH_WRITE_COUNTER, 8'h00);
    end_sim();
  end
endmodule // urm_top_tb
`default_nettype wire
